// [hw/mode_regs.svh]
// Offsets, field positions, mode codes and reset values of the mode handler
`ifndef MODE_REGS_SVH
`define MODE_REGS_SVH

// Word offsets inside a four-word descriptor entry
`define DESC_PTR_OFS 16'h0001
`define DESC_INFO_OFS 16'h0001
`define DESC_TT_OFS 16'h0002
`define DESC_DATA_OFS 16'h0003

// Word offsets inside an assigned indexed or ping-pong buffer
`define BUF_INFO_OFS 16'h0000
`define BUF_TT_OFS 16'h0001
`define BUF_DATA_OFS 16'h0002

// Command word fields
`define CMD_TR_BIT 10
`define CMD_DATA_BIT 4

// Mode codes
`define DYN_BUS_CODE 5'h00
`define TX_STATUS_CODE 5'h02
`define transmit_last_command_code 5'h12
`define transmit_selftest_word_code 5'h13

// Reset values
`define STATUS_RESET 3'h0
`define WORD_RESET 16'h0000

`endif

// [hw/mode_pkg.sv]
// Types shared by the mode command handler modules
package mode_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PTR = 4'h1,
		ST_ROUTE = 4'h2,
		ST_RX = 4'h3,
		ST_STATUS = 4'h4,
		ST_FETCH = 4'h5,
		ST_SEND = 4'h6,
		ST_WDATA = 4'h7,
		ST_WINFO = 4'h8,
		ST_WTT = 4'h9
	} state_t;

	typedef enum logic [1:0] {
		SRC_BUFFER = 2'h0,
		SRC_LAST = 2'h1,
		SRC_ST_PRI = 2'h2,
		SRC_ST_ALT = 2'h3
	} word_src_t;

	typedef struct packed {
		logic simplified_descriptor_storage_sel;
		logic undefined_codes_invalid_sel;
		logic alternate_selftest_word_sel;
	} term_cfg_t;

	typedef struct packed {
		logic terminal;
		logic broadcast;
		logic illegal;
		logic [15:0] word;
	} mode_cmd_t;

	typedef struct packed {
		logic rx_data;
		logic tx_data;
		logic bcast_ok;
		logic undefined;
		logic invalid;
		logic from_last;
		logic from_selftest;
	} mode_class_t;

	typedef struct packed {
		logic message_error_flag;
		logic dyn_bus_accept;
		logic broadcast_rcvd;
	} status_bits_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

endpackage

// [hw/mode_classifier.sv]
// Decodes a mode command word into its data direction and option classes
`include "mode_regs.svh"

module mode_classifier
	import mode_pkg::*;
(
	input wire logic [15:0] word,
	input wire logic undef_invalid,
	output mode_class_t cls
);
	logic tr;
	logic [4:0] code;

	always_comb
	begin
		tr = word[`CMD_TR_BIT];
		code = word[4:0];
		cls = '0;
		cls.rx_data = code[`CMD_DATA_BIT] && !tr;
		cls.tx_data = code[`CMD_DATA_BIT] && tr;
		// Codes 0-15 with T/R low, 16/18/19 receive, 17/20/21 transmit
		cls.undefined = (!tr && !code[4])
			|| (!tr && (code == 5'h10 || code == 5'h12 || code == 5'h13))
			|| (tr && (code == 5'h11 || code == 5'h14 || code == 5'h15));
		cls.invalid = cls.undefined && undef_invalid;
		if (tr)
			cls.bcast_ok = !code[4] && code != `DYN_BUS_CODE
				&& code != `TX_STATUS_CODE;
		else
			cls.bcast_ok = code[4] && !cls.undefined;
		cls.from_last = tr && code == `transmit_last_command_code;
		cls.from_selftest = tr && code == `transmit_selftest_word_code;
	end
endmodule

// [hw/mode_word_mux.sv]
// Picks the outgoing mode data word from its source
module mode_word_mux
	import mode_pkg::*;
(
	input word_src_t src,
	input wire logic [15:0] buf_word,
	input wire logic [15:0] last_word,
	input wire logic [15:0] st_pri,
	input wire logic [15:0] st_alt,
	output logic [15:0] word
);
	always_comb
	begin
		case (src)
			SRC_LAST: word = last_word;
			SRC_ST_PRI: word = st_pri;
			SRC_ST_ALT: word = st_alt;
			default: word = buf_word;
		endcase
	end
endmodule

// [hw/rt_mode_command_data_handler.sv]
// Mode command data handling for two remote terminals
module rt_mode_command_data_handler
	import mode_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmd_start,
	input mode_cmd_t cmd,
	input term_cfg_t [1:0] cfg,
	input wire logic [1:0][15:0] desc_base,
	input wire logic [1:0][15:0] selftest_word_pri,
	input wire logic [1:0][15:0] selftest_word_alt,
	input wire logic [15:0] time_tag,
	input wire logic rx_valid,
	input wire logic [15:0] rx_word,
	output logic status_req,
	output status_bits_t status,
	output logic tx_valid,
	output logic [15:0] tx_word,
	output mem_req_t mem,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack,
	output logic cmd_ignored,
	output logic busy
);
`include "mode_regs.svh"

	state_t state, next_state;
	mode_cmd_t cur, next_cur;
	logic [15:0] ptr, next_ptr;
	logic [15:0] data_word, next_data;
	status_bits_t next_status;
	logic next_status_req, next_tx_valid, next_ignored;
	logic [15:0] next_tx_word;
	mem_req_t next_mem;
	logic [1:0][15:0] last_cmd, next_last;

	logic idle;
	logic [15:0] cls_word;
	term_cfg_t tcfg;
	mode_class_t cls;
	word_src_t src;
	logic [15:0] mux_word;
	logic simp;
	logic [15:0] entry;

	function automatic logic [15:0] entry_addr(input logic [15:0] base,
		input logic [15:0] w);
		return base + {8'h00, w[`CMD_TR_BIT], w[4:0], 2'b00};
	endfunction

	// Simplified mode addresses the entry, standard mode the buffer
	function automatic logic [15:0] word_addr(input logic s,
		input logic [15:0] ent, input logic [15:0] p,
		input logic [15:0] dofs, input logic [15:0] bofs);
		return s ? ent + dofs : p + bofs;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decode of the incoming or current command

	assign idle = state == ST_IDLE;
	assign busy = !idle;
	assign cls_word = idle ? cmd.word : cur.word;
	assign tcfg = cfg[idle ? cmd.terminal : cur.terminal];
	assign simp = tcfg.simplified_descriptor_storage_sel;

	mode_classifier u_class (
		.word(cls_word),
		// Host option bit is low out of reset, so undefined codes start valid
		.undef_invalid(tcfg.undefined_codes_invalid_sel),
		.cls(cls)
	);

	always_comb
	begin
		if (cls.from_last)
			src = SRC_LAST;
		else if (cls.from_selftest)
			src = tcfg.alternate_selftest_word_sel ? SRC_ST_ALT : SRC_ST_PRI;
		else
			src = SRC_BUFFER;
	end

	mode_word_mux u_mux (
		.src(src),
		.buf_word(mem_rdata),
		.last_word(last_cmd[cur.terminal]),
		.st_pri(selftest_word_pri[cur.terminal]),
		.st_alt(selftest_word_alt[cur.terminal]),
		.word(mux_word)
	);

	////////////////////////////////////////////////////////////////////////
	// Message sequencer

	always_comb
	begin
		next_state = state;
		next_cur = cur;
		next_ptr = ptr;
		next_data = data_word;
		next_status = status;
		next_status_req = 1'b0;
		next_tx_valid = 1'b0;
		next_tx_word = tx_word;
		next_ignored = 1'b0;
		next_last = last_cmd;
		entry = '0;
		case (state)
			ST_IDLE:
			begin
				if (cmd_start && cls.invalid)
					next_ignored = 1'b1;
				else if (cmd_start)
				begin
					next_cur = cmd;
					// Broadcast of a non-broadcast code is handled as illegal
					next_cur.illegal = cmd.illegal
						|| (cmd.broadcast && !cls.bcast_ok);
					next_state = simp ? ST_ROUTE : ST_PTR;
				end
			end
			ST_PTR:
			begin
				if (mem_ack)
				begin
					next_ptr = mem_rdata;
					next_state = ST_ROUTE;
				end
			end
			ST_ROUTE:
			begin
				next_status.message_error_flag = cur.illegal;
				next_status.broadcast_rcvd = cur.broadcast;
				next_status.dyn_bus_accept = 1'b0;
				if (cls.rx_data && !cur.illegal)
					next_state = ST_RX;
				else
					next_state = ST_STATUS;
			end
			ST_RX:
			begin
				if (rx_valid)
				begin
					next_data = rx_word;
					next_state = ST_STATUS;
				end
			end
			ST_STATUS:
			begin
				next_status_req = !cur.broadcast;
				if (cls.tx_data && !cur.illegal && !cur.broadcast)
				begin
					if (src == SRC_BUFFER)
						next_state = ST_FETCH;
					else
					begin
						next_data = mux_word;
						next_state = ST_SEND;
					end
				end
				else if (cls.rx_data && !cur.illegal)
					next_state = ST_WDATA;
				else
					next_state = ST_WINFO;
			end
			ST_FETCH:
			begin
				if (mem_ack)
				begin
					next_data = mux_word;
					next_state = ST_SEND;
				end
			end
			ST_SEND:
			begin
				next_tx_valid = 1'b1;
				next_tx_word = data_word;
				next_state = ST_WDATA;
			end
			ST_WDATA:
				if (mem_ack)
					next_state = ST_WINFO;
			ST_WINFO:
				if (mem_ack)
					next_state = ST_WTT;
			ST_WTT:
			begin
				if (mem_ack)
				begin
					// A last-command request must not replace what it reports
					if (!cls.from_last)
						next_last[cur.terminal] = cur.word;
					next_state = ST_IDLE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase

		// Memory request follows the state that is entered
		entry = entry_addr(desc_base[next_cur.terminal], next_cur.word);
		next_mem = '0;
		case (next_state)
			ST_PTR:
			begin
				next_mem.req = 1'b1;
				next_mem.addr = entry + `DESC_PTR_OFS;
			end
			ST_FETCH:
			begin
				next_mem.req = 1'b1;
				next_mem.addr = word_addr(simp, entry, next_ptr,
					`DESC_DATA_OFS, `BUF_DATA_OFS);
			end
			ST_WDATA:
			begin
				next_mem.req = 1'b1;
				next_mem.we = 1'b1;
				next_mem.addr = word_addr(simp, entry, next_ptr,
					`DESC_DATA_OFS, `BUF_DATA_OFS);
				next_mem.wdata = next_data;
			end
			ST_WINFO:
			begin
				next_mem.req = 1'b1;
				next_mem.we = 1'b1;
				next_mem.addr = word_addr(simp, entry, next_ptr,
					`DESC_INFO_OFS, `BUF_INFO_OFS);
				next_mem.wdata = {next_cur.word[`CMD_TR_BIT],
					next_cur.broadcast, next_cur.illegal, 8'h00,
					next_cur.word[4:0]};
			end
			ST_WTT:
			begin
				next_mem.req = 1'b1;
				next_mem.we = 1'b1;
				next_mem.addr = word_addr(simp, entry, next_ptr,
					`DESC_TT_OFS, `BUF_TT_OFS);
				next_mem.wdata = time_tag;
			end
			default:
				next_mem = '0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			cur <= '0;
			ptr <= `WORD_RESET;
			data_word <= `WORD_RESET;
			status <= `STATUS_RESET;
			status_req <= 1'b0;
			tx_valid <= 1'b0;
			tx_word <= `WORD_RESET;
			mem <= '0;
			cmd_ignored <= 1'b0;
			last_cmd <= '0;
		end
		else
		begin
			state <= next_state;
			cur <= next_cur;
			ptr <= next_ptr;
			data_word <= next_data;
			status <= next_status;
			status_req <= next_status_req;
			tx_valid <= next_tx_valid;
			tx_word <= next_tx_word;
			mem <= next_mem;
			cmd_ignored <= next_ignored;
			last_cmd <= next_last;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_status_then_send;
		status_req && state == ST_SEND;
	endsequence

	property p_ignore_undefined;
		@(posedge clk_sys) disable iff (rst)
		idle && cmd_start && cls.invalid |=> idle && cmd_ignored
			&& !status_req && status == $past(status);
	endproperty
	a_ignore_undefined: assert property (p_ignore_undefined)
		else $error("undefined command was not ignored");

	property p_data_after_status;
		@(posedge clk_sys) disable iff (rst)
		s_status_then_send |=> tx_valid ##1 !tx_valid;
	endproperty
	a_data_after_status: assert property (p_data_after_status)
		else $error("status not followed by exactly one data word");

	property p_tx_only_legal;
		@(posedge clk_sys) disable iff (rst)
		tx_valid |-> cur.word[`CMD_DATA_BIT] && cur.word[`CMD_TR_BIT]
			&& !cur.illegal && !cur.broadcast;
	endproperty
	a_tx_only_legal: assert property (p_tx_only_legal)
		else $error("data word sent for a command without one");

	property p_error_flag;
		@(posedge clk_sys) disable iff (rst)
		state == ST_STATUS |-> status.message_error_flag == cur.illegal
			&& !status.dyn_bus_accept;
	endproperty
	a_error_flag: assert property (p_error_flag)
		else $error("message error flag disagrees with command");

	property p_rx_capture;
		@(posedge clk_sys) disable iff (rst)
		state == ST_RX && rx_valid |=> data_word == $past(rx_word)
			##[1:3] mem.req && mem.we && mem.wdata == data_word;
	endproperty
	a_rx_capture: assert property (p_rx_capture)
		else $error("received word not stored");

	property p_last_word;
		@(posedge clk_sys) disable iff (rst)
		state == ST_SEND && cls.from_last |->
			data_word == last_cmd[cur.terminal];
	endproperty
	a_last_word: assert property (p_last_word)
		else $error("last command word wrong");

	property p_selftest_word;
		@(posedge clk_sys) disable iff (rst)
		state == ST_SEND && cls.from_selftest |-> data_word ==
			(cfg[cur.terminal].alternate_selftest_word_sel ?
			selftest_word_alt[cur.terminal] :
			selftest_word_pri[cur.terminal]);
	endproperty
	a_selftest_word: assert property (p_selftest_word)
		else $error("self-test word from wrong register");

	property p_no_data_write;
		@(posedge clk_sys) disable iff (rst)
		state == ST_WDATA |-> cur.word[`CMD_DATA_BIT] && !cur.illegal;
	endproperty
	a_no_data_write: assert property (p_no_data_write)
		else $error("data word written for a code without data");

	property p_simp_addr;
		@(posedge clk_sys) disable iff (rst)
		state == ST_WDATA && simp |-> mem.addr ==
			entry_addr(desc_base[cur.terminal], cur.word) + `DESC_DATA_OFS;
	endproperty
	a_simp_addr: assert property (p_simp_addr)
		else $error("simplified data word outside its entry");
endmodule

// [verif/mode_ram_model.sv]
// Shared RAM model that answers the handler's memory requests
module mode_ram_model
	import mode_pkg::*;
(
	input wire logic clk_sys,
	input mem_req_t mem,
	input wire logic [3:0] wait_n,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] ram [0:1023];
	logic [3:0] cnt = 4'h0;
	logic [15:0] last = 16'h0000;
	////////////////////////////////////////////////////////////
	// Acks after wait_n stalled cycles, so slow RAM can be shown
	assign mem_ack = mem.req && cnt == wait_n;
	// Outside an ack the lines carry junk, so a stale sample shows up
	assign mem_rdata = mem_ack ? ram[mem.addr[9:0]] : ~last;
	always @(posedge clk_sys)
	begin
		cnt <= (mem_ack || !mem.req) ? 4'h0 : cnt + 4'h1;
		if (mem_ack)
		begin
			last <= mem_rdata;
			if (mem.we)
				ram[mem.addr[9:0]] <= mem.wdata;
		end
	end
endmodule

// [verif/test_rt_mode_command_data_handler.sv]
// Self-checking bench for the mode command data handler
module test_rt_mode_command_data_handler
	import mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cmd_start = 1'b0;
	mode_cmd_t cmd = '0;
	term_cfg_t [1:0] cfg = '0;
	logic [1:0][15:0] desc_base = {16'h0200, 16'h0100};
	logic [1:0][15:0] st_pri = {16'h2b2b, 16'h1a1a};
	logic [1:0][15:0] st_alt = {16'h2c2c, 16'h1c1c};
	logic [15:0] time_tag = 16'h7e01;
	logic rx_valid = 1'b0;
	logic [15:0] rx_word = 16'h0000;
	logic status_req, tx_valid, cmd_ignored, busy, mem_ack, saw_ign;
	status_bits_t status, held;
	logic [15:0] tx_word, mem_rdata, got_tx, e, want;
	mem_req_t mem;
	logic [3:0] wait_n = 4'h0;
	logic [4:0] rxc [0:6] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1f};
	logic [4:0] txc [0:4] = '{5'h10, 5'h11, 5'h14, 5'h15, 5'h1f};
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int n_stat, n_tx;

	always #25 clk_sys = ~clk_sys;

	rt_mode_command_data_handler rt_mode_command_data_handler_i (
		.clk_sys(clk_sys), .rst(rst), .cmd_start(cmd_start), .cmd(cmd),
		.cfg(cfg), .desc_base(desc_base), .selftest_word_pri(st_pri),
		.selftest_word_alt(st_alt), .time_tag(time_tag),
		.rx_valid(rx_valid), .rx_word(rx_word), .status_req(status_req),
		.status(status), .tx_valid(tx_valid), .tx_word(tx_word),
		.mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.cmd_ignored(cmd_ignored), .busy(busy)
	);

	mode_ram_model mode_ram_model_i (
		.clk_sys(clk_sys), .mem(mem), .wait_n(wait_n),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack)
	);

	////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [15:0] cw(input logic tr, input logic [4:0] c);
		return {5'h05, tr, 5'h1f, c};
	endfunction

	function automatic logic [15:0] ent(input logic t, tr,
		input logic [4:0] c);
		return desc_base[t] + {8'h00, tr, c, 2'b00};
	endfunction

	function automatic logic [15:0] rd(input logic [15:0] a);
		return mode_ram_model_i.ram[a[9:0]];
	endfunction

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		mode_ram_model_i.ram[a[9:0]] = d;
	endtask

	// One command, counting status and data replies until busy falls
	task automatic run(input logic t, bc, il, tr, input logic [4:0] c,
		input logic [15:0] rw);
		int k;
		@(negedge clk_sys);
		cmd = {t, bc, il, cw(tr, c)};
		rx_word = rw;
		cmd_start = 1'b1;
		n_stat = 0;
		n_tx = 0;
		saw_ign = 1'b0;
		for (k = 0; k < 60; k++)
		begin
			@(negedge clk_sys);
			cmd_start = 1'b0;
			n_stat += int'(status_req === 1'b1);
			n_tx += int'(tx_valid === 1'b1);
			if (tx_valid === 1'b1)
				got_tx = tx_word;
			saw_ign |= (cmd_ignored === 1'b1);
			// The data word stays offered until status shows it was taken
			rx_valid = !tr && c[4] && n_stat == 0;
			if (k > 1 && busy === 1'b0)
				break;
		end
		rx_valid = 1'b0;
		if (k == 60)
			errors++;
	endtask

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 1024; i++)
			wr(16'(i), 16'hdead);
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		check("busy", busy, 1'b0);
		check("status", status, 3'h0);
		check("mem req", mem.req, 1'b0);
		rst = 1'b0;
		$display("test reset done");
		wr(ent(0, 1, 5'h10) + 16'h0001, 16'h0300);
		wr(16'h0302, 16'hbeef);
		wait_n = 4'h3;
		run(0, 0, 0, 1, 5'h10, 16'h0000);
		wait_n = 4'h0;
		check("vector status", 16'(n_stat), 16'h0001);
		check("vector data", got_tx, 16'hbeef);
		check("vector info", rd(16'h0300), 16'h8010);
		check("vector tt", rd(16'h0301), time_tag);
		wr(ent(0, 1, 5'h12) + 16'h0001, 16'h0310);
		run(0, 0, 0, 1, 5'h12, 16'h0000);
		check("last cmd tx", got_tx, cw(1, 5'h10));
		check("last cmd stored", rd(16'h0312), cw(1, 5'h10));
		cfg[1].alternate_selftest_word_sel = 1'b1;
		for (int t = 0; t < 2; t++)
		begin
			e = 16'h0320 + 16'(t * 16);
			wr(ent(t[0], 1, 5'h13) + 16'h0001, e);
			run(t[0], 0, 0, 1, 5'h13, 16'h0000);
			want = t ? st_alt[1] : st_pri[0];
			check("selftest tx", got_tx, want);
			check("selftest stored", rd(e + 16'h0002), want);
		end
		$display("test transmit done");
		foreach (rxc[i])
		begin
			e = 16'h0400 + {9'h000, rxc[i], 2'b00};
			wr(ent(0, 0, rxc[i]) + 16'h0001, e);
			run(0, 0, 0, 0, rxc[i], {11'h528, rxc[i]});
			check("rx tx count", 16'(n_tx), 16'h0000);
			check("rx undefined kept", saw_ign, 1'b0);
			check("rx stored", rd(e + 16'h0002), {11'h528, rxc[i]});
			check("rx info", rd(e), {11'h000, rxc[i]});
		end
		foreach (txc[i])
		begin
			e = 16'h0500 + {9'h000, txc[i], 2'b00};
			wr(ent(0, 1, txc[i]) + 16'h0001, e);
			wr(e + 16'h0002, {11'h3b8, txc[i]});
			run(0, 0, 0, 1, txc[i], 16'h0000);
			check("tx count", 16'(n_tx), 16'h0001);
			check("tx word", got_tx, {11'h3b8, txc[i]});
		end
		for (int c = 1; c < 16; c++)
		begin
			e = 16'h0600 + 16'(c * 4);
			wr(ent(0, 1, 5'(c)) + 16'h0001, e);
			run(0, 0, 0, 1, 5'(c), 16'h0000);
			check("nodata status", 16'(n_stat), 16'h0001);
			check("nodata tx", 16'(n_tx), 16'h0000);
			check("nodata info", rd(e), {11'h400, 5'(c)});
			check("nodata buffer", rd(e + 16'h0002), 16'hdead);
		end
		$display("test receive and no-data done");
		cfg[1].simplified_descriptor_storage_sel = 1'b1;
		e = ent(1, 0, 5'h14);
		run(1, 0, 0, 0, 5'h14, 16'h4d4d);
		check("simple data", rd(e + 16'h0003), 16'h4d4d);
		check("simple info", rd(e + 16'h0001), 16'h0014);
		check("simple tt", rd(e + 16'h0002), time_tag);
		wr(ent(1, 1, 5'h10) + 16'h0003, 16'h6161);
		run(1, 0, 0, 1, 5'h10, 16'h0000);
		check("simple tx", got_tx, 16'h6161);
		$display("test simplified done");
		run(0, 0, 1, 1, 5'h10, 16'h0000);
		check("illegal status", 16'(n_stat), 16'h0001);
		check("illegal tx", 16'(n_tx), 16'h0000);
		check("illegal flag", status.message_error_flag, 1'b1);
		run(0, 1, 0, 1, 5'h01, 16'h0000);
		check("bcast reply", 16'(n_stat), 16'h0000);
		check("bcast flag", status.message_error_flag, 1'b0);
		check("bcast seen", status.broadcast_rcvd, 1'b1);
		run(0, 0, 0, 1, 5'h00, 16'h0000);
		check("dyn bus", status.dyn_bus_accept, 1'b0);
		check("dyn bus status", 16'(n_stat), 16'h0001);
		held = status;
		cfg[0].undefined_codes_invalid_sel = 1'b1;
		run(0, 0, 0, 1, 5'h11, 16'h0000);
		check("ignored", saw_ign, 1'b1);
		check("ignored reply", 16'(n_stat + n_tx), 16'h0000);
		// Broadcast, so a command that slipped through would move status
		run(0, 1, 0, 0, 5'h05, 16'h0000);
		check("ignored low code", saw_ign, 1'b1);
		check("ignored status", status, held);
		$display("test illegal and undefined done");
		final_report();
	end
endmodule
